// >>> bench/mps_carrier_model.sv
`timescale 1ns/10ps
module mps_carrier_model (
  input wire logic clk_i,
  input wire logic supply_ok_i,
  input wire logic ps_en_i,
  input wire logic fab_en_i,
  output logic power_off_request_n_o,
  output logic ps_rails_o,
  output logic fab_rails_o
);
  initial power_off_request_n_o = 1'b0;
  always @(negedge clk_i) begin
    power_off_request_n_o <= supply_ok_i;
    ps_rails_o <= ps_en_i;
    fab_rails_o <= fab_en_i;
  end
endmodule : mps_carrier_model

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb;
  import mps_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sup = 1'b0;
  logic shut_n = 1'b1;
  logic poff_n, ps, fab, por_n, rg, dom, cps, cfab;
  mps_wr_t wr = '0;
  mps_rails_t exp_q[$];
  mps_rails_t last_r = '0;
  mps_rails_t now_r;
  int fail_count = 0;
  int compares = 0;
  always #5 clk_i = ~clk_i;
  assign now_r = '{ps, fab, por_n, rg};
  mps_carrier_model carrier (.clk_i(clk_i), .supply_ok_i(sup), .ps_en_i(ps), .fab_en_i(fab),
    .power_off_request_n_o(poff_n), .ps_rails_o(cps), .fab_rails_o(cfab));
  mps_sequencer #(.STEP_CYC(4)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .power_off_request_n_i(poff_n), .module_shutdown_in_n_i(shut_n), .wr_i(wr),
    .ps_rail_enable_out_o(ps), .fabric_rail_enable_out_o(fab), .por_out_n_o(por_n),
    .regulators_on_o(rg), .fabric_domain_on_o(dom));
  task automatic test_done;
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic check(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      fail_count++;
      $display("MISMATCH %0t level %b", $time, got);
    end
  endtask : check
  task automatic note(input logic [15:0] s, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(mps_rails_t'(s[15-4*i -: 4]));
  endtask : note
  task automatic wait_lvl(input bit sel, input logic want);
    for (int i = 0; i < 300 && ((sel ? por_n : rg) !== want); i++) @(negedge clk_i);
    check(sel ? por_n : rg, want);
  endtask : wait_lvl
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic want);
    wr = '{1'b1, a, d};
    @(negedge clk_i) wr.we = 1'b0;
    repeat (3) @(negedge clk_i);
    check(dom, want);
  endtask : wr_reg
  always @(posedge clk_i) begin
    #1;
    if (now_r !== last_r) begin
      compares++;
      if (exp_q.size() == 0 || exp_q[0] !== now_r) begin
        fail_count++;
        $display("MISMATCH %0t rails %b", $time, now_r);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
      last_r = now_r;
    end
  end
  initial begin
    #100000;
    fail_count++;
    $display("MISMATCH %0t timeout", $time);
    test_done();
  end
  initial begin
    void'($urandom(32'h0C118D2C));
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat ($urandom_range(9, 2)) @(negedge clk_i);
    note(16'h19DF, 4);
    sup = 1'b1;
    repeat (6) @(negedge clk_i);
    shut_n = 1'b0;
    repeat (3) @(negedge clk_i);
    shut_n = 1'b1;
    wait_lvl(1'b1, 1'b1);
    note(16'hBF00, 2);
    wr_reg(8'h09, 8'h00, 1'b1);
    wr_reg(8'h08, 8'h00, 1'b0);
    wr_reg(8'h08, 8'($urandom_range(61, 1)), 1'b0);
    wr_reg(8'h08, 8'h3E, 1'b1);
    note(16'h9100, 3);
    sup = 1'b0;
    wait_lvl(1'b0, 1'b0);
    note(16'h19DF, 4);
    sup = 1'b1;
    wait_lvl(1'b1, 1'b1);
    check(cps && cfab, 1'b1);
    note(16'h9100, 3);
    shut_n = 1'b0;
    wait_lvl(1'b0, 1'b0);
    repeat (4) @(negedge clk_i);
    check(exp_q.size() == 0, 1'b1);
    test_done();
  end
endmodule : tb

// >>> design/mps_defines.svh
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH
`define MPS_REG_FABRIC_PWR 8'h08
`define MPS_FABRIC_OFF 8'h00
`define MPS_FABRIC_ON 8'h3E
`define MPS_STEP_NS 1000
`define MPS_STEP_CYC ((`MPS_STEP_NS + 9) / 10)
`endif

// >>> design/mps_pkg.sv
package mps_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP, ST_PS_EN, ST_FAB_EN, ST_RUN, ST_DOWN_FAB, ST_DOWN_PS
  } mps_state_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } mps_wr_t;
  typedef struct packed {
    logic ps_rail_enable_out;
    logic fabric_rail_enable_out;
    logic por_out_n;
    logic regulators_on;
  } mps_rails_t;
endpackage : mps_pkg

// >>> design/mps_sequencer.sv
`timescale 1ns/10ps
`include "mps_defines.svh"
module mps_sequencer #(
  parameter int STEP_CYC = `MPS_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic power_off_request_n_i,
  input wire logic module_shutdown_in_n_i,
  input wire mps_pkg::mps_wr_t wr_i,
  output logic ps_rail_enable_out_o,
  output logic fabric_rail_enable_out_o,
  output logic por_out_n_o,
  output logic regulators_on_o,
  output logic fabric_domain_on_o
);
  import mps_pkg::*;

  logic [1:0] poff_sync_q;
  logic [1:0] shdn_sync_q;
  logic shdn_prev_q;
  logic shdn_fall;
  logic power_ok;
  mps_state_t state_q;
  logic [15:0] cnt_q;
  logic step_done;
  logic fab_q;
  mps_rails_t rails_q;
  logic raw_fall;
  logic go_down;
  logic halt_q;
  logic [15:0] up_cnt_q;

  function automatic logic is_up(input mps_state_t s);
    return s inside {ST_RAMP, ST_PS_EN, ST_FAB_EN, ST_RUN};
  endfunction : is_up

  function automatic logic is_fab_write(input mps_wr_t w, input logic [7:0] v);
    return w.we && (w.addr == `MPS_REG_FABRIC_PWR) && (w.data == v);
  endfunction : is_fab_write

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      poff_sync_q <= 2'h0;
      shdn_sync_q <= 2'h3;
    end else begin
      poff_sync_q <= {poff_sync_q[0], power_off_request_n_i};
      shdn_sync_q <= {shdn_sync_q[0], module_shutdown_in_n_i};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shdn_prev_q <= 1'b1;
    end else begin
      shdn_prev_q <= shdn_sync_q[1];
    end
  end

  assign power_ok = poff_sync_q[1];
  assign raw_fall = shdn_prev_q && !shdn_sync_q[1];
  assign shdn_fall = raw_fall && rails_q.por_out_n;
  assign go_down = (!power_ok && is_up(state_q)) || (state_q == ST_RUN && shdn_fall);
  assign step_done = (cnt_q == 16'(STEP_CYC - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 16'h0000;
    end else if (step_done || go_down || state_q == ST_OFF || state_q == ST_RUN) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_OFF;
    end else if (go_down) begin
      state_q <= ST_DOWN_FAB;
    end else begin
      unique case (state_q)
        ST_OFF: if (power_ok && !halt_q) state_q <= ST_RAMP;
        ST_RAMP: if (step_done) state_q <= ST_PS_EN;
        ST_PS_EN: if (step_done) state_q <= ST_FAB_EN;
        ST_FAB_EN: if (step_done) state_q <= ST_RUN;
        ST_RUN: if (shdn_fall) state_q <= ST_DOWN_FAB;
        ST_DOWN_FAB: if (step_done) state_q <= ST_DOWN_PS;
        ST_DOWN_PS: if (step_done) state_q <= ST_OFF;
        default: state_q <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fab_q <= 1'b1;
    end else if (is_fab_write(wr_i, `MPS_FABRIC_OFF)) begin
      fab_q <= 1'b0;
    end else if (is_fab_write(wr_i, `MPS_FABRIC_ON)) begin
      fab_q <= 1'b1;
    end
  end

  // shutdown latch, held until the carrier cycles power-off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_q <= 1'b0;
    end else if (state_q == ST_RUN && shdn_fall) begin
      halt_q <= 1'b1;
    end else if (!power_ok) begin
      halt_q <= 1'b0;
    end
  end

  // cycles since the regulators came up
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_cnt_q <= 16'h0000;
    end else if (!rails_q.regulators_on) begin
      up_cnt_q <= 16'h0000;
    end else if (up_cnt_q != 16'hFFFF) begin
      up_cnt_q <= up_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rails_q <= '0;
    end else begin
      rails_q.regulators_on <= (state_q != ST_OFF);
      rails_q.ps_rail_enable_out <= (state_q inside {ST_PS_EN, ST_FAB_EN, ST_RUN}) ||
        (state_q == ST_DOWN_FAB && rails_q.ps_rail_enable_out);
      rails_q.fabric_rail_enable_out <= fab_q && state_q inside {ST_FAB_EN, ST_RUN};
      rails_q.por_out_n <= (state_q == ST_RUN);
    end
  end

  assign ps_rail_enable_out_o = rails_q.ps_rail_enable_out;
  assign fabric_rail_enable_out_o = rails_q.fabric_rail_enable_out;
  assign por_out_n_o = rails_q.por_out_n;
  assign regulators_on_o = rails_q.regulators_on;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fabric_domain_on_o <= 1'b0;
    end else begin
      fabric_domain_on_o <= fab_q && rails_q.regulators_on;
    end
  end

  sequence s_fall_seen;
    shdn_fall && state_q == ST_RUN;
  endsequence

  sequence s_down_begin;
    go_down && state_q == ST_RUN;
  endsequence

  sequence s_fab_dropped;
    !por_out_n_o && !fabric_rail_enable_out_o && ps_rail_enable_out_o && regulators_on_o;
  endsequence

  sequence s_ps_dropped;
    !ps_rail_enable_out_o && !fabric_rail_enable_out_o && regulators_on_o;
  endsequence

  chk_shutdown_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_fall_seen |=> state_q == ST_DOWN_FAB) else $error("shutdown not started");

  chk_ignore_before_por: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (raw_fall && !por_out_n_o && power_ok && is_up(state_q)) |=> state_q != ST_DOWN_FAB)
    else $error("shutdown seen before por");

  chk_por_after_rails: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(por_out_n_o) |-> ps_rail_enable_out_o && regulators_on_o)
    else $error("por released early");

  chk_por_rails_on: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    por_out_n_o |-> ps_rail_enable_out_o && regulators_on_o)
    else $error("por high without rails");

  chk_por_hold_time: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(por_out_n_o) |-> up_cnt_q >= 16'(3 * STEP_CYC))
    else $error("por released too soon");

  chk_ps_before_fab: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fabric_rail_enable_out_o |-> ps_rail_enable_out_o) else $error("fabric before ps");

  chk_ps_after_ramp: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(ps_rail_enable_out_o) |-> $past(regulators_on_o)) else $error("ps early");

  chk_poff_down: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!power_ok && state_q == ST_RUN) |=> state_q == ST_DOWN_FAB)
    else $error("power off ignored");

  chk_fab_off_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    is_fab_write(wr_i, `MPS_FABRIC_OFF) |=> ##1 !fabric_rail_enable_out_o)
    else $error("fabric off write ignored");

  chk_fab_on_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (is_fab_write(wr_i, `MPS_FABRIC_ON) && state_q == ST_RUN && !go_down)
    |=> ##1 fabric_rail_enable_out_o) else $error("fabric on write ignored");

  chk_ramp_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_q == ST_OFF && power_ok && !halt_q) |=> state_q == ST_RAMP) else $error("no ramp");

  chk_halt_holds_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_q == ST_OFF && halt_q) |=> state_q == ST_OFF) else $error("restart after shutdown");

  chk_down_order: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_down_begin |=> ##1 s_fab_dropped) else $error("fabric and por not first down");

  chk_ps_drop_order: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(ps_rail_enable_out_o) |-> s_ps_dropped) else $error("ps dropped out of order");

  chk_reg_off_last: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(regulators_on_o) |-> !ps_rail_enable_out_o && !por_out_n_o)
    else $error("regulators off early");

  chk_cnt_in_range: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cnt_q < 16'(STEP_CYC)) else $error("step counter overrun");
endmodule : mps_sequencer
